// >>> rtl/cic_pkg.sv
// constants and types shared by the interconnect control block
package cic_pkg;

  // register byte offsets on the apb slave
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] VECTOR_OFFSET = 8'h08;
  localparam logic [7:0] TRAP_OFFSET = 8'h0C;

  // control register fields and reset value
  localparam int CTRL_SNOOP_EN_BIT = 0;
  localparam int CTRL_LOCK_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;

  // status register fields
  localparam int STAT_VEC_FLAG_BIT = 0;
  localparam int STAT_LAST_LO_BIT = 1;
  localparam int STAT_LOCK_BIT = 3;
  localparam int STAT_TRAP_BIT = 4;

  // interconnect address word layout
  localparam int MASK_LO_BIT = 28;
  localparam int FC_LO_BIT = 25;
  localparam int PA_LO_BIT = 2;
  localparam int PA_HI_BIT = 23;

  // function codes on the interconnect
  localparam logic [2:0] FC_READ = 3'h0;
  localparam logic [2:0] FC_READ_LOCK = 3'h1;
  localparam logic [2:0] FC_READ_MODIFY = 3'h2;
  localparam logic [2:0] FC_WRITE = 3'h4;
  localparam logic [2:0] FC_WRITE_UNLOCK = 3'h5;
  localparam logic [2:0] FC_WRITE_VECTOR = 3'h6;

  // slave status codes
  localparam logic [1:0] STS_NXM = 2'h0;
  localparam logic [1:0] STS_UCE = 2'h1;
  localparam logic [1:0] STS_CORR = 2'h2;
  localparam logic [1:0] STS_OK = 2'h3;

  // byte masks
  localparam logic [3:0] MASK_ALL = 4'hF;

  // microtrap codes: cause n gives code n+1, bus error its own
  localparam int TRAP_CAUSES = 7;
  localparam logic [3:0] TRAP_BUS_ERROR = 4'h8;

  // read-lock timeout
  localparam int LOCK_TIME_US = 64;
  localparam int CLK_MHZ = 200;
  localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;

  // bus functions from the microword; the last three have bit 4 set
  typedef enum logic [4:0] {
    BF_NONE, BF_READ_PHYS, BF_READ_NO_TRAP, BF_READ_LOCK_TEST, BF_READ_SECOND,
    BF_WRITE_PHYS, BF_WRITE_SECOND, BF_WRITE_UNLOCK_SECOND, BF_WRITE_NO_TRAP,
    BF_WRITE_LONG_NO_TRAP, BF_BUS_GRANT, BF_READ, BF_READ_LONG, BF_READ_LOCK,
    BF_READ_MODIFY, BF_READ_LONG_MODIFY, BF_WRITE, BF_WRITE_LONG, BF_WRITE_UNLOCK
  } cic_bus_func_type;

  typedef enum logic [2:0] {ST_IDLE, ST_LOCK, ST_ADDR, ST_DATA, ST_WAIT} cic_state_type;

  // interconnect pins seen by the block
  typedef struct packed {
    logic [31:0] data;
    logic bus_busy;
    logic [1:0] status;
    logic status_strobe;
    logic cpu_pri;
  } cic_link_in_type;

  typedef struct packed {
    logic [31:0] data;
    logic data_oe_n;
    logic bus_busy;
    logic bus_busy_oe_n;
    logic [1:0] status;
    logic status_oe_n;
    logic hold;
  } cic_link_out_type;

endpackage : cic_pkg

// >>> rtl/cic_top.sv
// interconnect control: byte mask, function code, snoop, lock timer, microtrap
//
// Behaviour
// R1: all mask bits high for long, physical, prefetch
// R2: other reads: mask from low address bits
// R3: other writes: mask from size and address
// R4: second-reference writes use their own mask table
// R5: mask bit 28 upward validates byte 0 upward
// R6: three-bit function code encoding for transfers
// R7: prefetch drives function code zero, plain read
// R8: slave returns two-bit status with data
// R9: answer write-vector with no-error status
// R10: assert bus busy on every processor address cycle
// R11: register bus busy; rising edge marks I/O address
// R12: I/O write: assert hold and snoop request
// R13: snoop routes address to cache, invalidates hit
// R14: start read-lock timer on detected read lock
// R15: lock timeout sets vector flag, sends nonexistent status
// R16: act as slave to write-vector cycles
// R17: one address register loaded from bus or processor
// R18: microtrap causes encoded by fixed priority
// R19: microtrap drives vector bits 3:0 with sequencer 5:4
// R20: failed write raises write bus error
// R21: micro clock at half rate, phase one aligned
// R22: early bus function bit 4 holds off prefetch
// R23: general-register destination suppresses writes, not prefetch
`timescale 1ns/1ps
`default_nettype none
module cic_top #(
  parameter int LOCK_LIMIT = cic_pkg::LOCK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cic_pkg::cic_bus_func_type bus_func,
  input wire logic [31:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  input wire logic [1:0] data_size,
  input wire logic dest_is_general_register,
  input wire logic prefetch_req,
  input wire logic [6:0] trap_cause,
  input wire logic [1:0] seq_vector_hi,
  input wire logic cache_match,
  input wire cic_pkg::cic_link_in_type link_in,
  output cic_pkg::cic_link_out_type link_out,
  output logic phase1,
  output logic micro_clk_en,
  output logic io_write_snoop,
  output logic [21:0] snoop_addr,
  output logic cache_invalidate,
  output logic cycle_done,
  output logic [31:0] rd_data,
  output logic [1:0] rd_status,
  output logic write_bus_error,
  output logic vector_written_flag,
  output logic trap_active,
  output logic [5:0] microvector
);

  typedef struct packed {
    cic_pkg::cic_state_type st;
    logic phase1;
    logic mclk_en;
    logic early_bit4;
    cic_pkg::cic_bus_func_type bf;
    logic [31:0] addr;
    logic [1:0] size;
    logic is_wr;
    logic [31:0] wdata;
    logic busy_q;
    cic_pkg::cic_link_out_type lo;
    logic snoop;
    logic inval;
    logic vec_pend;
    logic [31:0] vector;
    logic vec_flag;
    logic lock_act;
    logic [15:0] lock_cnt;
    logic nxm_trap;
    logic wbe;
    logic done;
    logic [31:0] rdata;
    logic [1:0] rstat;
    logic trap;
    logic [5:0] uvec;
    logic [1:0] ctrl;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cic_regs_type;

  cic_regs_type r;
  cic_regs_type next_r;

  function automatic logic is_write(input cic_pkg::cic_bus_func_type f);
    case (f)
      cic_pkg::BF_WRITE_PHYS, cic_pkg::BF_WRITE_SECOND, cic_pkg::BF_WRITE_UNLOCK_SECOND,
      cic_pkg::BF_WRITE_NO_TRAP, cic_pkg::BF_WRITE_LONG_NO_TRAP, cic_pkg::BF_WRITE,
      cic_pkg::BF_WRITE_LONG, cic_pkg::BF_WRITE_UNLOCK: is_write = 1'b1;
      default: is_write = 1'b0;
    endcase
  endfunction : is_write

  // function code field of a processor address word; prefetch overrides it with a plain read
  function automatic logic [2:0] func_code(input cic_pkg::cic_bus_func_type f);
    case (f)
      cic_pkg::BF_READ_LOCK, cic_pkg::BF_READ_LOCK_TEST: func_code = cic_pkg::FC_READ_LOCK; // see R6
      cic_pkg::BF_READ_MODIFY, cic_pkg::BF_READ_LONG_MODIFY: func_code = cic_pkg::FC_READ_MODIFY;
      cic_pkg::BF_WRITE_UNLOCK, cic_pkg::BF_WRITE_UNLOCK_SECOND: func_code = cic_pkg::FC_WRITE_UNLOCK;
      default: func_code = is_write(f) ? cic_pkg::FC_WRITE : cic_pkg::FC_READ;
    endcase
  endfunction : func_code

  // byte mask; bit 0 of the result is byte 0 (address bit 28)
  function automatic logic [3:0] byte_mask(input cic_pkg::cic_bus_func_type f, input logic prefetch,
                                           input logic [1:0] size, input logic [1:0] low);
    logic [3:0] from_low;
    from_low = cic_pkg::MASK_ALL << low;
    case (f)
      cic_pkg::BF_READ_PHYS, cic_pkg::BF_READ_SECOND, cic_pkg::BF_BUS_GRANT,
      cic_pkg::BF_WRITE_LONG_NO_TRAP, cic_pkg::BF_WRITE_PHYS, cic_pkg::BF_WRITE_LONG,
      cic_pkg::BF_READ_LONG, cic_pkg::BF_READ_LONG_MODIFY: byte_mask = cic_pkg::MASK_ALL; // see R1
      cic_pkg::BF_WRITE_SECOND, cic_pkg::BF_WRITE_UNLOCK_SECOND:
        if (size[1] && low[1])
          byte_mask = low[0] ? 4'h7 : 4'h3; // see R4
        else
          byte_mask = 4'h1; // see R4
      default:
        if (!is_write(f))
          byte_mask = from_low; // see R2
        else if (size == 2'h0)
          byte_mask = 4'h1 << low; // see R3
        else if (size == 2'h1)
          byte_mask = (low == 2'h3) ? 4'h8 : 4'(4'h3 << low); // see R3
        else
          byte_mask = from_low; // see R3
    endcase
    if (prefetch)
      byte_mask = cic_pkg::MASK_ALL; // see R1
  endfunction : byte_mask

  function automatic logic [31:0] reg_read(input logic [7:0] a, input cic_regs_type s);
    case (a)
      cic_pkg::CTRL_OFFSET: reg_read = {30'h0, s.ctrl};
      cic_pkg::STATUS_OFFSET: reg_read = {27'h0, s.trap, s.lock_act, s.rstat, s.vec_flag};
      cic_pkg::VECTOR_OFFSET: reg_read = s.vector;
      cic_pkg::TRAP_OFFSET: reg_read = {26'h0, s.uvec};
      default: reg_read = 32'h0;
    endcase
  endfunction : reg_read

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == cic_pkg::CTRL_OFFSET) || (a == cic_pkg::STATUS_OFFSET) ||
             (a == cic_pkg::VECTOR_OFFSET) || (a == cic_pkg::TRAP_OFFSET);
  endfunction : mapped

  always_comb
  begin
    logic io_addr;
    logic [2:0] seen_fc;
    logic apb_write;
    logic want_cycle;
    logic take_prefetch;
    logic [3:0] code;
    logic any_cause;
    io_addr = 1'b0;
    seen_fc = 3'h0;
    apb_write = 1'b0;
    want_cycle = 1'b0;
    take_prefetch = 1'b0;
    code = 4'h0;
    any_cause = 1'b0;
    next_r = r;

    // half-rate micro clock; bus function latched with phase one
    next_r.phase1 = !r.phase1; // see R21
    next_r.mclk_en = !r.phase1; // see R21
    if (!r.phase1)
      next_r.early_bit4 = bus_func[4]; // see R22
    if (next_r.mclk_en && r.bf == cic_pkg::BF_NONE)
      next_r.bf = bus_func;

    // pulses default inactive: enables high, the rest low
    next_r.snoop = 1'b0;
    next_r.inval = 1'b0;
    next_r.done = 1'b0;
    next_r.wbe = 1'b0;
    next_r.nxm_trap = 1'b0;
    next_r.lo.data_oe_n = 1'b1;
    next_r.lo.bus_busy = 1'b0;
    next_r.lo.bus_busy_oe_n = 1'b1;
    next_r.lo.status_oe_n = 1'b1;
    next_r.lo.hold = 1'b0;

    // watch the link for addresses placed by other masters
    next_r.busy_q = link_in.bus_busy; // see R11
    seen_fc = link_in.data[cic_pkg::FC_LO_BIT +: 3];
    // our own address cycle also raises bus busy; it must not be taken for an I/O address,
    // while an I/O address must still be seen when we are waiting for the link
    io_addr = link_in.bus_busy && !r.busy_q && r.lo.bus_busy_oe_n; // see R11
    if (io_addr)
    begin
      next_r.addr = link_in.data; // see R17
      if ((seen_fc == cic_pkg::FC_WRITE || seen_fc == cic_pkg::FC_WRITE_UNLOCK)
          && r.ctrl[cic_pkg::CTRL_SNOOP_EN_BIT])
      begin
        next_r.lo.hold = 1'b1; // see R12
        next_r.snoop = 1'b1; // see R12
      end
      if (seen_fc == cic_pkg::FC_WRITE_VECTOR)
      begin
        next_r.vec_pend = 1'b1; // see R16
        next_r.lo.status = cic_pkg::STS_OK; // see R9
        next_r.lo.status_oe_n = 1'b0; // see R9
      end
      if (seen_fc == cic_pkg::FC_READ_LOCK && r.ctrl[cic_pkg::CTRL_LOCK_EN_BIT])
      begin
        next_r.lock_act = 1'b1; // see R14
        next_r.lock_cnt = 16'h0; // see R14
      end
      if (seen_fc == cic_pkg::FC_WRITE_UNLOCK)
        next_r.lock_act = 1'b0;
    end
    if (r.snoop)
    begin
      next_r.lo.hold = 1'b1; // see R12
      next_r.inval = cache_match; // see R13
    end
    if (r.vec_pend)
    begin
      next_r.vector = link_in.data; // see R16
      next_r.vec_flag = 1'b1; // see R16
      next_r.vec_pend = 1'b0;
    end
    if (r.lock_act && r.lock_cnt != 16'hFFFF)
      next_r.lock_cnt = r.lock_cnt + 16'h1; // see R14

    // processor cycles
    want_cycle = r.bf != cic_pkg::BF_NONE && r.bf != cic_pkg::BF_BUS_GRANT
                 && !(is_write(r.bf) && dest_is_general_register); // see R23
    take_prefetch = prefetch_req && !r.early_bit4 && !want_cycle; // see R22
    if (r.bf == cic_pkg::BF_BUS_GRANT || (r.bf != cic_pkg::BF_NONE && !want_cycle))
      next_r.bf = cic_pkg::BF_NONE;
    case (r.st)
      cic_pkg::ST_IDLE:
        if ((want_cycle || take_prefetch) && !r.snoop && !r.vec_pend)
        begin
          next_r.addr = cpu_addr; // see R17
          next_r.size = data_size;
          next_r.is_wr = want_cycle && is_write(r.bf);
          next_r.wdata = cpu_wdata;
          next_r.lo.data = {byte_mask(r.bf, take_prefetch, data_size, cpu_addr[1:0]), // see R5
                            take_prefetch ? cic_pkg::FC_READ : func_code(r.bf), // see R7
                            cpu_addr[24:0]};
          next_r.bf = cic_pkg::BF_NONE;
          next_r.st = r.lock_act ? cic_pkg::ST_LOCK : cic_pkg::ST_ADDR;
        end
      cic_pkg::ST_LOCK:
        if (!r.lock_act)
          next_r.st = cic_pkg::ST_ADDR;
        else if (r.lock_cnt >= 16'(LOCK_LIMIT - 1))
        begin
          next_r.vec_flag = 1'b1; // see R15
          next_r.nxm_trap = 1'b1; // see R15
          next_r.rstat = cic_pkg::STS_NXM; // see R15
          next_r.lock_act = 1'b0;
          next_r.done = 1'b1;
          next_r.st = cic_pkg::ST_IDLE;
        end
      cic_pkg::ST_ADDR:
        if (link_in.cpu_pri)
        begin
          next_r.lo.data_oe_n = 1'b0;
          next_r.lo.bus_busy = 1'b1; // see R10
          next_r.lo.bus_busy_oe_n = 1'b0; // see R10
          next_r.st = r.is_wr ? cic_pkg::ST_DATA : cic_pkg::ST_WAIT;
        end
      cic_pkg::ST_DATA:
      begin
        next_r.lo.data = r.wdata;
        next_r.lo.data_oe_n = 1'b0;
        next_r.st = cic_pkg::ST_WAIT;
      end
      cic_pkg::ST_WAIT:
        if (link_in.status_strobe)
        begin
          next_r.rdata = link_in.data;
          next_r.rstat = link_in.status; // see R8
          next_r.done = 1'b1;
          next_r.wbe = r.is_wr && link_in.status != cic_pkg::STS_OK; // see R20
          next_r.nxm_trap = link_in.status == cic_pkg::STS_NXM || link_in.status == cic_pkg::STS_UCE;
          next_r.st = cic_pkg::ST_IDLE;
        end
      default: next_r.st = cic_pkg::ST_IDLE;
    endcase

    // microtrap priority encoder, cause 0 is highest
    for (int i = cic_pkg::TRAP_CAUSES - 1; i >= 0; i--)
      if (trap_cause[i])
      begin
        code = 4'(i + 1); // see R18
        any_cause = 1'b1;
      end
    if (!any_cause && r.nxm_trap)
    begin
      code = cic_pkg::TRAP_BUS_ERROR; // see R15
      any_cause = 1'b1;
    end
    next_r.trap = any_cause;
    if (any_cause)
      next_r.uvec = {seq_vector_hi, code}; // see R19

    // apb slave, one wait state
    next_r.pready = psel && penable && !r.pready;
    if (psel && penable && !r.pready)
    begin
      next_r.prdata = reg_read(paddr, r);
      next_r.pslverr = !mapped(paddr);
    end
    apb_write = psel && penable && r.pready && pwrite;
    if (apb_write && paddr == cic_pkg::CTRL_OFFSET)
      next_r.ctrl = pwdata[1:0];
    // flag set by hardware in this cycle wins over the clear
    if (apb_write && paddr == cic_pkg::STATUS_OFFSET && pwdata[cic_pkg::STAT_VEC_FLAG_BIT]
        && !(r.vec_pend || next_r.nxm_trap && r.st == cic_pkg::ST_LOCK))
      next_r.vec_flag = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.st <= cic_pkg::ST_IDLE;
      r.bf <= cic_pkg::BF_NONE;
      r.ctrl <= cic_pkg::CTRL_RESET;
      r.lo.data_oe_n <= 1'b1;
      r.lo.bus_busy_oe_n <= 1'b1;
      r.lo.status_oe_n <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign link_out = r.lo;
  assign phase1 = r.phase1;
  assign micro_clk_en = r.mclk_en;
  assign io_write_snoop = r.snoop;
  assign snoop_addr = r.addr[cic_pkg::PA_HI_BIT:cic_pkg::PA_LO_BIT];
  assign cache_invalidate = r.inval;
  assign cycle_done = r.done;
  assign rd_data = r.rdata;
  assign rd_status = r.rstat;
  assign write_bus_error = r.wbe;
  assign vector_written_flag = r.vec_flag;
  assign trap_active = r.trap;
  assign microvector = r.uvec;

endmodule : cic_top
`default_nettype wire

// >>> bench/cic_top_properties.sv
// concurrent checks on the interconnect control block ports
`timescale 1ns/1ps
`default_nettype none
module cic_top_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [6:0] trap_cause,
  input wire logic [1:0] seq_vector_hi,
  input wire logic cache_match,
  input wire cic_pkg::cic_link_in_type link_in,
  input wire cic_pkg::cic_link_out_type link_out,
  input wire logic phase1,
  input wire logic micro_clk_en,
  input wire logic io_write_snoop,
  input wire logic [21:0] snoop_addr,
  input wire logic cache_invalidate,
  input wire logic cycle_done,
  input wire logic [1:0] rd_status,
  input wire logic trap_active,
  input wire logic [5:0] microvector
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic own_addr = !link_out.bus_busy_oe_n && link_out.bus_busy;

  function automatic logic [3:0] prio(input logic [6:0] c);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 6; i >= 0; i--)
      if (c[i])
        r = 4'(i + 1);
    return r;
  endfunction : prio

  chk_addr_on_data: assert property (own_addr |-> !link_out.data_oe_n)
    else $error("bus busy driven without an address on the data lines");
  chk_busy_single: assert property (own_addr |=> !own_addr)
    else $error("bus busy held past the address cycle");
  chk_fc_legal: assert property (own_addr |-> link_out.data[27:25] inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5})
    else $error("processor issued an undefined or vector function code");
  chk_snoop_cause: assert property (io_write_snoop |-> $past(link_in.bus_busy) && !$past(link_in.bus_busy, 2)
    && $past(link_in.data[27:26]) == 2'b10)
    else $error("snoop without a new write address");
  chk_snoop_hold: assert property (io_write_snoop |-> link_out.hold ##1 link_out.hold)
    else $error("hold missing during snoop");
  chk_snoop_addr: assert property (io_write_snoop |-> snoop_addr == $past(link_in.data[23:2]))
    else $error("snoop address differs from captured address");
  chk_invalidate: assert property (io_write_snoop && cache_match |=> cache_invalidate)
    else $error("cache hit on snoop not invalidated");
  chk_vector_ok: assert property (!link_out.status_oe_n |-> link_out.status == cic_pkg::STS_OK)
    else $error("driven status is not the no-error code");
  chk_status_pass: assert property (cycle_done && $past(link_in.status_strobe)
    |-> rd_status == $past(link_in.status))
    else $error("returned status not passed on");
  chk_trap_code: assert property ($past(presetn) && $past(trap_cause) != 7'h00 |-> trap_active
    && microvector == {$past(seq_vector_hi), prio($past(trap_cause))})
    else $error("microvector does not match highest priority cause");
  chk_half_rate: assert property ($past(presetn) |-> phase1 != $past(phase1))
    else $error("phase did not alternate");
  chk_micro_edge: assert property (micro_clk_en |-> phase1 && !$past(phase1))
    else $error("micro clock enable not aligned to first phase");
endmodule : cic_top_properties
bind cic_top cic_top_properties u_props (.pclk, .presetn, .trap_cause, .seq_vector_hi, .cache_match, .link_in,
  .link_out, .phase1, .micro_clk_en, .io_write_snoop, .snoop_addr, .cache_invalidate, .cycle_done, .rd_status,
  .trap_active, .microvector);
`default_nettype wire

// >>> bench/cic_link_partner.sv
// memory controller and I/O adapter model on the far side of the interconnect
`timescale 1ns/1ps
`default_nettype none
module cic_link_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire cic_pkg::cic_link_out_type link_out,
  output cic_pkg::cic_link_in_type link_in
);
  logic [31:0] own_data = 32'h0, prev = 32'h0, last_word = 32'h0, last_wdata = 32'h0, resp_data = 32'h0;
  logic own_drv = 0, own_busy = 0, own_strobe = 0, cpu_pri = 1;
  logic [1:0] own_status = 2'h0, resp_status = cic_pkg::STS_OK, prev_st = 2'h0;
  int n_addr = 0;
  int delay = 2;
  // released data and status lines show the inverse of their last value; the function field parks on an undefined code
  always_comb
  begin
    link_in.bus_busy = own_busy | (!link_out.bus_busy_oe_n & link_out.bus_busy);
    link_in.data = !link_out.data_oe_n ? link_out.data : own_drv ? own_data : {~prev[31:28], 3'b011, ~prev[24:0]};
    link_in.status = !link_out.status_oe_n ? link_out.status : own_strobe ? own_status : ~prev_st;
    link_in.status_strobe = own_strobe;
    link_in.cpu_pri = cpu_pri;
  end
  always @(posedge pclk)
  begin
    prev <= link_in.data;
    prev_st <= link_in.status;
  end
  // answer each processor address cycle after a programmable delay
  always
  begin
    @(posedge pclk);
    if (presetn && !link_out.bus_busy_oe_n && link_out.bus_busy)
    begin
      last_word = link_out.data;
      n_addr++;
      if (last_word[27])
      begin
        @(posedge pclk);
        last_wdata = link_in.data;
      end
      repeat (delay) @(posedge pclk);
      own_drv <= 1;
      own_strobe <= 1;
      own_data <= resp_data;
      own_status <= resp_status;
      @(posedge pclk);
      own_drv <= 0;
      own_strobe <= 0;
    end
  end
  // I/O master cycle: address word, then data word; waits out hold first
  task automatic io_cycle(input logic [2:0] fc, input logic [31:0] a, input logic [31:0] d, input logic busy);
    @(posedge pclk);
    while (link_out.hold === 1'b1) @(posedge pclk);
    cpu_pri <= 0;
    own_drv <= 1;
    own_busy <= busy;
    own_data <= {4'hF, fc, a[24:0]};
    @(posedge pclk);
    own_busy <= 0;
    own_data <= d;
    @(posedge pclk);
    own_drv <= 0;
    cpu_pri <= 1;
  endtask : io_cycle
endmodule : cic_link_partner
`default_nettype wire

// >>> bench/cic_top_tb_top.sv
// self-checking bench for the interconnect control block
`timescale 1ns/1ps
`default_nettype none
module cic_top_tb_top;
  import cic_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, ev;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, cpu_addr = 32'h0, cpu_wdata = 32'h0, rd_data, rv;
  cic_bus_func_type bus_func = BF_NONE;
  logic [1:0] data_size = 2'h0, seq_vector_hi = 2'h0, rd_status, st_seen = 2'h0;
  logic dest_is_general_register = 0, prefetch_req = 0, cache_match = 0;
  logic [6:0] trap_cause = 7'h00;
  cic_link_in_type link_in;
  cic_link_out_type link_out;
  logic phase1, micro_clk_en, io_write_snoop, cache_invalidate, cycle_done, write_bus_error;
  logic vector_written_flag, trap_active;
  logic [21:0] snoop_addr, snoop_at = 22'h0;
  logic [5:0] microvector;
  logic [6:0] tc [3] = '{7'h7F, 7'h48, 7'h40};
  logic [3:0] tcode [3] = '{4'h1, 4'h4, 4'h7};
  localparam logic [31:0] SA = 32'h00ABCDE4;
  int err_count = 0, comparisons = 0, n_snoop = 0, n_inval = 0, n_wbe = 0, n0;

  always #2.5 pclk = ~pclk;
  cic_top #(.LOCK_LIMIT(20)) dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .bus_func, .cpu_addr, .cpu_wdata, .data_size, .dest_is_general_register, .prefetch_req, .trap_cause,
    .seq_vector_hi, .cache_match, .link_in, .link_out, .phase1, .micro_clk_en, .io_write_snoop, .snoop_addr,
    .cache_invalidate, .cycle_done, .rd_data, .rd_status, .write_bus_error, .vector_written_flag, .trap_active,
    .microvector);
  cic_link_partner far (.pclk, .presetn, .link_out, .link_in);

  // tallies of pulses the sequence cannot sit and wait on
  always @(posedge pclk)
  begin
    n_snoop <= n_snoop + int'(io_write_snoop === 1'b1);
    n_inval <= n_inval + int'(cache_invalidate === 1'b1);
    n_wbe <= n_wbe + int'(write_bus_error === 1'b1);
    if (io_write_snoop === 1'b1) snoop_at <= snoop_addr;
    if (link_out.status_oe_n === 1'b0) st_seen <= link_out.status;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wrap_up;
    if (err_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task automatic cpu(input cic_bus_func_type f, input logic pf, input logic [1:0] sz, input logic [31:0] a,
                     input int lim);
    int n;
    n = 0;
    @(posedge pclk);
    bus_func <= f;
    prefetch_req <= pf;
    data_size <= sz;
    cpu_addr <= a;
    cpu_wdata <= ~a;
    // a bus function stands for one micro cycle only, else it is latched again
    while (cycle_done !== 1'b1 && n < lim)
    begin
      @(posedge pclk);
      n++;
      if (n == 2)
        bus_func <= BF_NONE;
      if (link_out.bus_busy === 1'b1)
        prefetch_req <= 1'b0;
    end
  endtask : cpu

  task automatic bus_case(input cic_bus_func_type f, input logic pf, input logic [1:0] sz, input logic [1:0] lo,
                          input logic [3:0] m, input logic [2:0] fc);
    n0 = far.n_addr;
    cpu(f, pf, sz, {30'h0048D150, lo}, 200);
    chk("cycles", 32'(n0 + 1), 32'(far.n_addr));
    chk("mask", 32'(m), 32'(far.last_word[31:28]));
    chk("fcode", 32'(fc), 32'(far.last_word[27:25]));
    if (!pf) chk("addr", {7'h0, 23'h048D150, lo}, {7'h0, far.last_word[24:0]});
  endtask : bus_case

  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    apb(0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, 32'(ev));
    bus_case(BF_NONE, 1, 2'd0, 2'd2, 4'hF, FC_READ);
    bus_case(BF_READ_LONG, 0, 2'd0, 2'd3, 4'hF, FC_READ);
    bus_case(BF_READ_PHYS, 0, 2'd0, 2'd3, 4'hF, FC_READ);
    bus_case(BF_READ, 0, 2'd0, 2'd1, 4'hE, FC_READ);
    bus_case(BF_READ_LOCK, 0, 2'd0, 2'd2, 4'hC, FC_READ_LOCK);
    bus_case(BF_READ_MODIFY, 0, 2'd0, 2'd3, 4'h8, FC_READ_MODIFY);
    bus_case(BF_WRITE, 0, 2'd0, 2'd1, 4'h2, FC_WRITE);
    bus_case(BF_WRITE, 0, 2'd1, 2'd1, 4'h6, FC_WRITE);
    bus_case(BF_WRITE_UNLOCK, 0, 2'd2, 2'd1, 4'hE, FC_WRITE_UNLOCK);
    bus_case(BF_WRITE_SECOND, 0, 2'd2, 2'd3, 4'h7, FC_WRITE);
    bus_case(BF_WRITE_UNLOCK_SECOND, 0, 2'd3, 2'd2, 4'h3, FC_WRITE_UNLOCK);
    bus_case(BF_WRITE_SECOND, 0, 2'd1, 2'd3, 4'h1, FC_WRITE);
    bus_case(BF_WRITE_LONG, 0, 2'd0, 2'd1, 4'hF, FC_WRITE);
    far.resp_status = STS_CORR;
    far.resp_data = 32'h5A5A0F0F;
    bus_case(BF_READ_LONG_MODIFY, 0, 2'd0, 2'd2, 4'hF, FC_READ_MODIFY);
    chk("rd_status", 32'(STS_CORR), 32'(rd_status));
    chk("rd_data", 32'h5A5A0F0F, rd_data);
    far.resp_status = STS_NXM;
    bus_case(BF_WRITE_LONG_NO_TRAP, 0, 2'd0, 2'd2, 4'hF, FC_WRITE);
    far.resp_status = STS_OK;
    repeat (3) @(posedge pclk);
    chk("wr_error", 32'h1, 32'(n_wbe));
    dest_is_general_register <= 1;
    n0 = far.n_addr;
    cpu(BF_WRITE, 0, 2'd0, 32'h0, 40);
    chk("suppressed", 32'(n0), 32'(far.n_addr));
    bus_func <= BF_NONE;
    dest_is_general_register <= 0;
    cache_match <= 1;
    far.io_cycle(FC_WRITE, SA, 32'h1, 1);
    repeat (4) @(posedge pclk);
    chk("snoops", 32'h1, 32'(n_snoop));
    chk("snoop_addr", 32'(SA[23:2]), 32'(snoop_at));
    cache_match <= 0;
    far.io_cycle(FC_WRITE_UNLOCK, SA, 32'h2, 1);
    far.io_cycle(FC_READ, SA, 32'h3, 1);
    repeat (4) @(posedge pclk);
    chk("snoops", 32'h2, 32'(n_snoop));
    chk("invalidates", 32'h1, 32'(n_inval));
    far.io_cycle(FC_READ_LOCK, SA, 32'h4, 1);
    n0 = far.n_addr;
    cpu(BF_READ, 0, 2'd0, 32'h0, 200);
    chk("lock_status", 32'(STS_NXM), 32'(rd_status));
    chk("lock_flag", 32'h1, 32'(vector_written_flag));
    chk("lock_cycles", 32'(n0), 32'(far.n_addr));
    far.io_cycle(FC_WRITE_UNLOCK, SA, 32'h5, 1);
    apb(1, STATUS_OFFSET, 32'h1);
    apb(0, STATUS_OFFSET, 32'h0);
    chk("flag_clear", 32'h0, 32'(rv[STAT_VEC_FLAG_BIT]));
    far.io_cycle(FC_WRITE_VECTOR, 32'h0, 32'h000001F4, 1);
    repeat (3) @(posedge pclk);
    chk("vec_status", 32'(STS_OK), 32'(st_seen));
    chk("vec_flag", 32'h1, 32'(vector_written_flag));
    apb(0, VECTOR_OFFSET, 32'h0);
    chk("vector", 32'h000001F4, rv);
    foreach (tc[i])
    begin
      @(posedge pclk);
      trap_cause <= tc[i];
      seq_vector_hi <= 2'(i);
      repeat (2) @(posedge pclk);
      chk("microvector", 32'({2'(i), tcode[i]}), 32'(microvector));
    end
    trap_cause <= 7'h00;
    wrap_up();
  end

  initial
  begin
    #100000;
    err_count++;
    wrap_up();
  end
endmodule : cic_top_tb_top
`default_nettype wire
